// >>> hw/gls_busy_eval.sv
// Carrier sense evaluation from relative rise and absolute level
`timescale 1ns/10ps
module gls_busy_eval (
  input wire logic [8:0] level_db,
  input wire logic [8:0] baseline_db,
  input wire logic [7:0] setpoint_db,
  input wire logic [1:0] busy_channel_rise_threshold,
  input wire logic [3:0] busy_channel_level_threshold,
  output logic rise_hit,
  output logic level_hit,
  output logic busy
);
  logic [9:0] rise;
  logic signed [10:0] thr;
  logic signed [10:0] lvl;
  logic rise_en;
  logic level_en;

  always_comb
  begin
    rise = {1'b0, level_db} - {1'b0, baseline_db};
    rise_en = busy_channel_rise_threshold != gls_pkg::REL_OFF;
    rise_hit = rise_en && !rise[9] &&
      (rise >= {2'b00,
      gls_pkg::REL_RISE_DB[busy_channel_rise_threshold]});
    // Signed offset in 1 dB steps around the setpoint
    thr = $signed({3'b000, setpoint_db}) +
      {{7{busy_channel_level_threshold[3]}},
      busy_channel_level_threshold};
    lvl = $signed({2'b00, level_db});
    level_en = busy_channel_level_threshold != gls_pkg::ABS_OFF;
    level_hit = level_en && (lvl >= thr);
    busy = rise_hit || level_hit;
  end
endmodule

// >>> hw/gls_cfg.sv
// Gain ceiling, setpoint and carrier sense configuration block on APB
//
// Implementation choices: the placing of the registers and register access over APB.
`timescale 1ns/10ps
// Functional notes
// - Digital gain code drops top 0..3 settings
// - Front amp code lowers combined gain ceiling
// - Setpoint code picks 24..42 dB target
// - Order bit 1: cut first amp first
// - Order bit 0: second amp to minimum first
// - Rise code asserts busy at 6/10/14 dB
// - Rise code zero disables rise criterion
// - Signed level threshold relative to setpoint
// - Level code 1000 disables level criterion
// - Level compared as amplitude plus gain cut
module gls_cfg #(
  parameter int GW = 3,
  parameter int DW = 3
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic dig_step_up,
  input wire logic dig_step_down,
  input wire logic front_step_up,
  input wire logic front_step_down,
  input wire logic [7:0] chan_amp_db,
  input wire logic [7:0] gain_cut_db,
  input wire logic busy_restart,
  output logic [DW-1:0] dig_gain,
  output logic [GW-1:0] amp1_gain,
  output logic [GW-1:0] amp2_gain,
  output logic [7:0] amplitude_setpoint_db,
  output logic carrier_sense
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  localparam logic [DW-1:0] DIG_TOP = '1;
  localparam logic [GW:0] FRONT_TOP = {1'b0, {GW{1'b1}}} << 1;

  typedef struct packed {
    logic [1:0] digital_gain_ceiling;
    logic [2:0] front_amp_gain_ceiling;
    logic [2:0] amplitude_setpoint;
    logic gain_reduction_order;
    logic [1:0] busy_channel_rise_threshold;
    logic [3:0] busy_channel_level_threshold;
    logic [DW-1:0] dig;
    logic [GW-1:0] amp1;
    logic [GW-1:0] amp2;
    logic [8:0] baseline;
    logic [7:0] setpt_db;
    logic busy;
    logic rise_hit;
    logic level_hit;
    logic [31:0] rdata;
    logic err;
  } gls_state_s;

  gls_state_s st;
  gls_state_s next_st;

  logic setup;
  logic wr;
  logic [7:0] reg0;
  logic [7:0] reg1;
  logic [31:0] stat;
  logic [DW-1:0] dig_max;
  logic [GW:0] front_max;
  logic [GW-1:0] step_amp1;
  logic [GW-1:0] step_amp2;
  logic [8:0] level;
  logic ev_rise;
  logic ev_level;
  logic ev_busy;

  // ----------------------------------------------------------------
  // Limits and level scale
  // ----------------------------------------------------------------
  always_comb
  begin
    dig_max = DIG_TOP - DW'(st.digital_gain_ceiling);
    front_max = FRONT_TOP - (GW+1)'(st.front_amp_gain_ceiling);
    // Gain cut added back so the scale is the amplitude without cuts
    level = {1'b0, chan_amp_db} + {1'b0, gain_cut_db};
  end

  gls_order_step #(
    .GW(GW)
  ) u_order (
    .amp1_gain(st.amp1),
    .amp2_gain(st.amp2),
    .front_max(front_max),
    .gain_reduction_order(st.gain_reduction_order),
    .step_down(front_step_down),
    .step_up(front_step_up),
    .next_amp1(step_amp1),
    .next_amp2(step_amp2)
  );

  gls_busy_eval u_busy (
    .level_db(level),
    .baseline_db(st.baseline),
    .setpoint_db(st.setpt_db),
    .busy_channel_rise_threshold(st.busy_channel_rise_threshold),
    .busy_channel_level_threshold(st.busy_channel_level_threshold),
    .rise_hit(ev_rise),
    .level_hit(ev_level),
    .busy(ev_busy)
  );

  // ----------------------------------------------------------------
  // Register images
  // ----------------------------------------------------------------
  always_comb
  begin
    reg0 = '0;
    reg0[gls_pkg::DIG_CEIL_LSB +: 2] = st.digital_gain_ceiling;
    reg0[gls_pkg::FRONT_CEIL_LSB +: 3] = st.front_amp_gain_ceiling;
    reg0[gls_pkg::SETPT_LSB +: 3] = st.amplitude_setpoint;
    // Bit 7 of the second register is reserved and reads zero
    reg1 = '0;
    reg1[gls_pkg::ORDER_BIT] = st.gain_reduction_order;
    reg1[gls_pkg::REL_THR_LSB +: 2] = st.busy_channel_rise_threshold;
    reg1[gls_pkg::ABS_THR_LSB +: 4] = st.busy_channel_level_threshold;
    stat = '0;
    stat[0] = st.busy;
    stat[1] = st.rise_hit;
    stat[2] = st.level_hit;
    stat[8 +: DW] = st.dig;
    stat[16 +: GW] = st.amp1;
    stat[24 +: GW] = st.amp2;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    setup = psel && !penable;
    wr = psel && penable && pwrite && pstrb[0];
    // Read data and error are fixed in the setup cycle so both come
    // from flops during the single access cycle
    if (setup)
    begin
      next_st.err = 1'b0;
      next_st.rdata = '0;
      unique case (paddr)
        gls_pkg::OFS_CEIL_SETPT:
          next_st.rdata = {24'h000000, reg0};
        gls_pkg::OFS_ORDER_THR:
          next_st.rdata = {24'h000000, reg1};
        gls_pkg::OFS_STATUS:
        begin
          next_st.rdata = stat;
          next_st.err = pwrite;
        end
        default:
          next_st.err = 1'b1;
      endcase
    end
    if (wr && paddr == gls_pkg::OFS_CEIL_SETPT)
    begin
      next_st.digital_gain_ceiling =
        pwdata[gls_pkg::DIG_CEIL_LSB +: 2];
      next_st.front_amp_gain_ceiling =
        pwdata[gls_pkg::FRONT_CEIL_LSB +: 3];
      next_st.amplitude_setpoint = pwdata[gls_pkg::SETPT_LSB +: 3];
    end
    if (wr && paddr == gls_pkg::OFS_ORDER_THR)
    begin
      next_st.gain_reduction_order = pwdata[gls_pkg::ORDER_BIT];
      next_st.busy_channel_rise_threshold =
        pwdata[gls_pkg::REL_THR_LSB +: 2];
      next_st.busy_channel_level_threshold =
        pwdata[gls_pkg::ABS_THR_LSB +: 4];
    end
    next_st.setpt_db = gls_pkg::SETPT_DB[st.amplitude_setpoint];

    // Digital gain: a ceiling lowered under the current gain pulls it
    // down at once instead of waiting for the next step request
    if (st.dig > dig_max)
      next_st.dig = dig_max;
    else if (dig_step_down && st.dig != '0)
      next_st.dig = st.dig - 1'b1;
    else if (dig_step_up && st.dig < dig_max)
      next_st.dig = st.dig + 1'b1;

    next_st.amp1 = step_amp1;
    next_st.amp2 = step_amp2;

    // The rise reference is the level at the start of listening
    if (busy_restart)
      next_st.baseline = level;
    next_st.rise_hit = ev_rise && !busy_restart;
    next_st.level_hit = ev_level;
    next_st.busy = (ev_rise && !busy_restart) || ev_level;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st.digital_gain_ceiling <= gls_pkg::DIG_CEIL_RST;
      st.front_amp_gain_ceiling <= gls_pkg::FRONT_CEIL_RST;
      st.amplitude_setpoint <= gls_pkg::SETPT_RST;
      st.gain_reduction_order <= gls_pkg::ORDER_RST;
      st.busy_channel_rise_threshold <= gls_pkg::REL_THR_RST;
      st.busy_channel_level_threshold <= gls_pkg::ABS_THR_RST;
      st.dig <= '0;
      st.amp1 <= '0;
      st.amp2 <= '0;
      st.baseline <= '0;
      st.setpt_db <= gls_pkg::SETPT_DB[gls_pkg::SETPT_RST];
      st.busy <= 1'b0;
      st.rise_hit <= 1'b0;
      st.level_hit <= 1'b0;
      st.rdata <= '0;
      st.err <= 1'b0;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign pready = 1'b1;
  assign prdata = st.rdata;
  assign pslverr = st.err && psel && penable;
  assign dig_gain = st.dig;
  assign amp1_gain = st.amp1;
  assign amp2_gain = st.amp2;
  assign amplitude_setpoint_db = st.setpt_db;
  assign carrier_sense = st.busy;
endmodule

// >>> hw/gls_order_step.sv
// Front amplifier gain stepping with selectable reduction order
`timescale 1ns/10ps
module gls_order_step #(
  parameter int GW = 3
) (
  input wire logic [GW-1:0] amp1_gain,
  input wire logic [GW-1:0] amp2_gain,
  input wire logic [GW:0] front_max,
  input wire logic gain_reduction_order,
  input wire logic step_down,
  input wire logic step_up,
  output logic [GW-1:0] next_amp1,
  output logic [GW-1:0] next_amp2
);
  localparam logic [GW-1:0] TOP = '1;
  logic [GW:0] sum;
  logic down;

  always_comb
  begin
    sum = {1'b0, amp1_gain} + {1'b0, amp2_gain};
    // Sitting above the ceiling forces a step down
    down = step_down || (sum > front_max);
    next_amp1 = amp1_gain;
    next_amp2 = amp2_gain;
    if (down)
    begin
      if (gain_reduction_order)
      begin
        if (amp1_gain != '0)
          next_amp1 = amp1_gain - 1'b1;
        else if (amp2_gain != '0)
          next_amp2 = amp2_gain - 1'b1;
      end
      else
      begin
        if (amp2_gain != '0)
          next_amp2 = amp2_gain - 1'b1;
        else if (amp1_gain != '0)
          next_amp1 = amp1_gain - 1'b1;
      end
    end
    else if (step_up && (sum < front_max))
    begin
      // Gain comes back in the reverse of the order it was given up
      if (gain_reduction_order)
      begin
        if (amp2_gain != TOP)
          next_amp2 = amp2_gain + 1'b1;
        else
          next_amp1 = amp1_gain + 1'b1;
      end
      else
      begin
        if (amp1_gain != TOP)
          next_amp1 = amp1_gain + 1'b1;
        else
          next_amp2 = amp2_gain + 1'b1;
      end
    end
  end
endmodule

// >>> hw/gls_pkg.sv
// Package: register map, field layout and code tables of the gain config block
package gls_pkg;
  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CEIL_SETPT = 8'h00;
  localparam logic [7:0] OFS_ORDER_THR = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int DIG_CEIL_LSB = 6;
  localparam int FRONT_CEIL_LSB = 3;
  localparam int SETPT_LSB = 0;
  localparam int ORDER_BIT = 6;
  localparam int REL_THR_LSB = 4;
  localparam int ABS_THR_LSB = 0;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] DIG_CEIL_RST = 2'h0;
  localparam logic [2:0] FRONT_CEIL_RST = 3'h0;
  localparam logic [2:0] SETPT_RST = 3'h3;
  localparam logic ORDER_RST = 1'b1;
  localparam logic [1:0] REL_THR_RST = 2'h0;
  localparam logic [3:0] ABS_THR_RST = 4'h0;
  // ----------------------------------------------------------------
  // Code tables
  // ----------------------------------------------------------------
  localparam logic [1:0] REL_OFF = 2'h0;
  localparam logic [3:0] ABS_OFF = 4'h8;
  localparam logic [7:0] REL_RISE_DB [4] = '{8'h00, 8'h06, 8'h0a, 8'h0e};
  localparam logic [7:0] SETPT_DB [8] =
    '{8'h18, 8'h1b, 8'h1e, 8'h21, 8'h24, 8'h26, 8'h28, 8'h2a};
endpackage

// >>> tb/gls_cfg_sva.sv
// Checker: port-level assertions for the gain and carrier sense config block
`timescale 1ns/10ps
module gls_cfg_sva #(
  parameter int GW = 3,
  parameter int DW = 3
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic front_step_down,
  input wire logic [7:0] chan_amp_db,
  input wire logic [7:0] gain_cut_db,
  input wire logic busy_restart,
  input wire logic [DW-1:0] dig_gain,
  input wire logic [GW-1:0] amp1_gain,
  input wire logic [GW-1:0] amp2_gain,
  input wire logic [7:0] amplitude_setpoint_db,
  input wire logic carrier_sense
);
  localparam logic [7:0] SP [8] =
    '{8'h18, 8'h1b, 8'h1e, 8'h21, 8'h24, 8'h26, 8'h28, 8'h2a};
  // ----------------------------------------------------------------
  // Shadow of the writable fields except the setpoint code, and of the rise baseline
  // ----------------------------------------------------------------
  logic [1:0] dc;
  logic [2:0] fc;
  logic ord;
  logic [1:0] rel;
  logic [3:0] lt;
  logic [8:0] base;
  logic base_ok;
  wire logic wr = psel && penable && pwrite && pstrb[0];
  wire logic [8:0] lvl = {1'b0, chan_amp_db} + {1'b0, gain_cut_db};
  wire logic lvl_hit = $signed({2'b0, lvl}) >=
    $signed({3'b0, amplitude_setpoint_db}) + $signed(lt);
  wire logic [7:0] rise = rel == 2'h1 ? 8'h06 : rel == 2'h2 ? 8'h0a : 8'h0e;
  wire logic rise_hit = {1'b0, lvl} >= {1'b0, base} + {2'b0, rise};
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      dc <= 2'h0;
      fc <= 3'h0;
      ord <= 1'b1;
      rel <= 2'h0;
      lt <= 4'h0;
      base <= 9'h000;
      base_ok <= 1'b0;
    end
    else
    begin
      if (wr && paddr == gls_pkg::OFS_CEIL_SETPT)
        {dc, fc} <= pwdata[7:3];
      if (wr && paddr == gls_pkg::OFS_ORDER_THR)
        {ord, rel, lt} <= pwdata[6:0];
      if (busy_restart)
        base <= lvl;
      if (busy_restart)
        base_ok <= 1'b1;
    end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_wr0;
    wr && paddr == gls_pkg::OFS_CEIL_SETPT;
  endsequence
  sequence s_off;
    rel == 2'h0 && lt == 4'h8;
  endsequence
  a_dig_ceiling: assert property ($stable(dc) |->
    int'(dig_gain) <= 7 - int'(dc)) else $error("digital gain above ceiling");
  // Convergence takes one drop per cycle, so allow eight quiet cycles
  a_front_ceiling: assert property ($stable(fc) [*8] |->
    int'(amp1_gain) + int'(amp2_gain) <= 14 - int'(fc))
    else $error("front gain above ceiling");
  a_setpt_code: assert property (s_wr0 |=> ##1
    amplitude_setpoint_db == SP[$past(pwdata[2:0], 2)])
    else $error("setpoint dB wrong");
  a_cut_first: assert property (ord && front_step_down
    && amp1_gain != '0
    |=> amp1_gain == $past(amp1_gain) - 1'b1 && $stable(amp2_gain))
    else $error("first amp not cut first");
  a_cut_second: assert property (!ord && front_step_down
    && amp2_gain != '0
    |=> amp2_gain == $past(amp2_gain) - 1'b1 && $stable(amp1_gain))
    else $error("second amp not cut first");
  a_rise_hit: assert property (lt == 4'h8 && rel != 2'h0 && base_ok
    && !busy_restart |=> carrier_sense == $past(rise_hit))
    else $error("rise criterion wrong");
  a_level_hit: assert property (rel == 2'h0 && lt != 4'h8
    |=> carrier_sense == $past(lvl_hit)) else $error("level criterion wrong");
  a_busy_off: assert property (s_off [*2] |=> !carrier_sense)
    else $error("busy with both criteria off");
endmodule

bind gls_cfg gls_cfg_sva #(.GW(GW), .DW(DW)) gls_cfg_sva_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .front_step_down(front_step_down), .chan_amp_db(chan_amp_db),
  .gain_cut_db(gain_cut_db), .busy_restart(busy_restart),
  .dig_gain(dig_gain), .amp1_gain(amp1_gain), .amp2_gain(amp2_gain),
  .amplitude_setpoint_db(amplitude_setpoint_db),
  .carrier_sense(carrier_sense)
);

// >>> tb/testbench.sv
// Testbench: register, carrier sense and gain step checks of the config block
`timescale 1ns/10ps
module testbench;
  typedef struct {
    logic [7:0] r0;
    logic [7:0] r4;
    logic [7:0] amp;
    logic [7:0] cut;
    logic [7:0] sp;
    logic cs;
  } gls_row_s;
  // Baseline is 20 dB, so the rise rows sit at 26, 29 and 34 dB
  gls_row_s rows [8] = '{
    '{8'h00, 8'h08, 8'h3c, 8'h00, 8'h18, 1'b0},
    '{8'h01, 8'h00, 8'h1b, 8'h00, 8'h1b, 1'b1},
    '{8'h02, 8'h0f, 8'h1c, 8'h00, 8'h1e, 1'b0},
    '{8'h03, 8'h09, 8'h1a, 8'h00, 8'h21, 1'b1},
    '{8'h04, 8'h07, 8'h28, 8'h03, 8'h24, 1'b1},
    '{8'h05, 8'h18, 8'h1a, 8'h00, 8'h26, 1'b1},
    '{8'h06, 8'h28, 8'h1d, 8'h00, 8'h28, 1'b0},
    '{8'hff, 8'hb8, 8'h22, 8'h00, 8'h2a, 1'b1}};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic [3:0] st = 4'h0;
  logic [7:0] amp = 8'h00;
  logic [7:0] cut = 8'h00;
  logic restart = 1'b0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready;
  logic pslverr;
  logic er;
  logic [2:0] dig_gain;
  logic [2:0] amp1_gain;
  logic [2:0] amp2_gain;
  logic [7:0] amplitude_setpoint_db;
  logic carrier_sense;
  int miscompares = 0;
  int cmp_count = 0;
  always #5 pclk = ~pclk;
  gls_cfg #(.GW(3), .DW(3)) gls_cfg_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dig_step_up(st[0]), .dig_step_down(st[1]),
    .front_step_up(st[2]), .front_step_down(st[3]),
    .chan_amp_db(amp), .gain_cut_db(cut), .busy_restart(restart),
    .dig_gain(dig_gain), .amp1_gain(amp1_gain), .amp2_gain(amp2_gain),
    .amplitude_setpoint_db(amplitude_setpoint_db),
    .carrier_sense(carrier_sense)
  );
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      miscompares++;
    end
  endtask
  // An idle cycle follows each transfer so no strobe is driven twice at once
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    if (k >= 20)
      miscompares++;
    if (k >= 20)
      end_sim();
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task step(input logic [3:0] s, input int n);
    repeat (n)
    begin
      st <= s;
      @(posedge pclk);
    end
    st <= 4'h0;
    @(posedge pclk);
  endtask
  initial
  begin
    repeat (5000) @(posedge pclk);
    miscompares++;
    end_sim();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(32'(amplitude_setpoint_db), 32'h21);
    chk(32'({dig_gain, amp1_gain, amp2_gain, carrier_sense}), 32'h0);
    apb(1'b0, gls_pkg::OFS_CEIL_SETPT, 32'h0);
    chk(rd, 32'h3);
    apb(1'b0, gls_pkg::OFS_ORDER_THR, 32'h0);
    chk(rd, 32'h40);
    $display("reset test done");
    amp <= 8'h14;
    restart <= 1'b1;
    @(posedge pclk);
    restart <= 1'b0;
    foreach (rows[i])
    begin
      amp <= rows[i].amp;
      cut <= rows[i].cut;
      apb(1'b1, gls_pkg::OFS_CEIL_SETPT, {24'h0, rows[i].r0});
      apb(1'b1, gls_pkg::OFS_ORDER_THR, {24'h0, rows[i].r4});
      repeat (3) @(posedge pclk);
      chk(32'(amplitude_setpoint_db), 32'(rows[i].sp));
      chk(32'(carrier_sense), 32'(rows[i].cs));
      apb(1'b0, gls_pkg::OFS_ORDER_THR, 32'h0);
      chk(rd, {24'h0, rows[i].r4 & 8'h7f});
      $display("row %0d done", i);
    end
    apb(1'b1, gls_pkg::OFS_CEIL_SETPT, 32'h03);
    step(4'h1, 8);
    chk(32'(dig_gain), 32'h7);
    // Lowering the ceiling under the gain must pull it down at once
    apb(1'b1, gls_pkg::OFS_CEIL_SETPT, 32'hc3);
    step(4'h4, 16);
    chk(32'(dig_gain), 32'h4);
    chk(32'({amp1_gain, amp2_gain}), 32'h3f);
    apb(1'b1, gls_pkg::OFS_ORDER_THR, 32'h08);
    step(4'h8, 3);
    chk(32'({amp1_gain, amp2_gain}), 32'h3c);
    apb(1'b1, gls_pkg::OFS_ORDER_THR, 32'h48);
    step(4'h8, 2);
    chk(32'({amp1_gain, amp2_gain}), 32'h2c);
    apb(1'b1, gls_pkg::OFS_CEIL_SETPT, 32'hfb);
    repeat (12) @(posedge pclk);
    chk(32'(amp1_gain) + 32'(amp2_gain), 32'h7);
    apb(1'b0, gls_pkg::OFS_STATUS, 32'h0);
    chk(rd, 32'h04030400);
    step(4'h2, 2);
    chk(32'(dig_gain), 32'h2);
    // Down wins when both step requests come together
    step(4'h3, 1);
    chk(32'(dig_gain), 32'h1);
    $display("gain test done");
    pstrb <= 4'h0;
    apb(1'b1, gls_pkg::OFS_CEIL_SETPT, 32'h07);
    pstrb <= 4'hf;
    apb(1'b0, gls_pkg::OFS_CEIL_SETPT, 32'h0);
    chk(rd, 32'hfb);
    apb(1'b1, 8'h08, 32'hff);
    chk(32'(er), 32'h1);
    apb(1'b0, 8'h0c, 32'h0);
    chk({rd[30:0], er}, 32'h1);
    $display("refusal test done");
    end_sim();
  end
endmodule
